// ==== design/speed_table_pkg.sv ====
// package: register map, table geometry and write-word layout of the speed table sequencer
package speed_table_pkg;
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_LOCO      = 8'h04;
  localparam logic [7:0] ADDR_TABLE     = 8'h08;
  localparam logic [7:0] ADDR_STATUS    = 8'h0C;
  localparam logic [7:0] ADDR_DONE      = 8'h10;
  localparam logic [7:0] ADDR_EDIT_ADDR = 8'h14;
  localparam logic [7:0] ADDR_EDIT_DATA = 8'h18;

  localparam int CTRL_START_BIT  = 0;
  localparam int CTRL_CANCEL_BIT = 1;
  localparam int ST_BUSY_BIT     = 0;
  localparam int ST_DONE_BIT     = 1;
  localparam int ST_REJECT_BIT   = 2;
  localparam int ST_CV_POS       = 8;
  localparam int ST_VALUE_POS    = 24;
  localparam int DONE_TABLE_POS  = 16;
  localparam int EDIT_TAB_POS    = 5;

  localparam int N_TABLES  = 8;
  localparam int N_ENTRIES = 28;
  localparam int FIFO_DEPTH = 16;

  localparam logic [9:0] CV_FIRST  = 10'h043;
  localparam logic [9:0] CV_LAST   = 10'h05E;
  localparam logic [9:0] CV_CONFIG = 10'h01D;
  localparam logic [9:0] CV_VENDOR = 10'h019;
  localparam logic [2:0] SEL_BIT   = 3'h4;
  localparam logic [7:0] VOLT_MAX  = 8'hFF;
  localparam logic [4:0] LAST_IDX  = 5'h1B;
  localparam logic [3:0] TAB_MAX   = 4'h8;

  localparam logic [13:0] LOCO_RESET  = 14'h0003;
  localparam logic [3:0]  TABLE_RESET = 4'h1;

  typedef struct packed {
    logic [13:0] loco;
    logic [9:0]  cv;
    logic        bit_mode;
    logic [2:0]  bit_pos;
    logic [7:0]  value;
  } cv_write_s;

  typedef enum logic [1:0] {IDLE, ENTRIES, CONFIG_BIT, VENDOR_BIT} seq_state_e;

  // tables are numbered from 1; zero and anything above eight are refused
  function automatic logic index_ok(input logic [3:0] idx);
    return (idx != 4'h0) && (idx <= TAB_MAX);
  endfunction

  // default ramp, slightly flatter for each higher table
  function automatic logic [7:0] default_entry(input logic [2:0] tab, input logic [4:0] e);
    logic [15:0] top;
    logic [15:0] prod;
    top  = {8'h00, VOLT_MAX} - {9'h000, tab, 4'h0};
    prod = top * ({11'h000, e} + 16'h0001);
    return 8'((prod / 16'(N_ENTRIES)));
  endfunction
endpackage

// ==== design/speed_table_sequencer.sv ====
// speed table download sequencer with apb registers and outgoing write fifo
//
// The APB slave port and the register addresses were decided locally.
module speed_table_sequencer
  import speed_table_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        backup_ok,
  output logic                             pkt_valid,
  input  wire logic                        pkt_ready,
  output speed_table_pkg::cv_write_s       pkt
);
  import speed_table_pkg::*;

  seq_state_e  state;
  logic [13:0] loco;
  logic [3:0]  table_sel;
  logic [13:0] run_loco;
  logic [2:0]  run_tab;
  logic [4:0]  idx;
  logic        done;
  logic        rejected;
  logic [13:0] done_loco;
  logic [3:0]  done_table;
  logic [9:0]  cur_cv;
  logic [7:0]  cur_value;
  logic [2:0]  edit_tab;
  logic [4:0]  edit_idx;
  logic        backup_meta;
  logic        backup_sync;
  logic        restore;

  cv_write_s   word;
  logic        push;
  logic        fifo_ready;
  logic [7:0]  entry_value;
  logic [7:0]  edit_value;
  logic        wr_en;
  logic        rd_setup;
  logic        mapped;
  logic        start_req;
  logic        cancel_req;
  logic        edit_we;
  logic [31:0] next_rdata;

  // backup supply flag from a pin, two stages before use
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      backup_meta <= 1'b1;
      backup_sync <= 1'b1;
    end else begin
      backup_meta <= backup_ok;
      backup_sync <= backup_meta;
    end
  end

  assign restore = !backup_sync;

  // apb decode: zero-wait slave, unmapped offsets flag an error
  assign mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_LOCO) ||
                  (paddr == ADDR_TABLE) || (paddr == ADDR_STATUS) ||
                  (paddr == ADDR_DONE) || (paddr == ADDR_EDIT_ADDR) ||
                  (paddr == ADDR_EDIT_DATA);
  assign pready     = 1'b1;
  assign pslverr    = psel && penable && !mapped;
  assign wr_en      = psel && penable && pwrite && mapped;
  assign rd_setup   = psel && !penable && !pwrite;
  assign start_req  = wr_en && paddr == ADDR_CTRL && pwdata[CTRL_START_BIT];
  assign cancel_req = wr_en && paddr == ADDR_CTRL && pwdata[CTRL_CANCEL_BIT];
  assign edit_we    = wr_en && paddr == ADDR_EDIT_DATA;

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (paddr)
      ADDR_LOCO:      next_rdata = {18'h00000, loco};
      ADDR_TABLE:     next_rdata = {28'h0000000, table_sel};
      ADDR_STATUS: begin
        next_rdata[ST_BUSY_BIT]                 = state != IDLE;
        next_rdata[ST_DONE_BIT]                 = done;
        next_rdata[ST_REJECT_BIT]               = rejected;
        next_rdata[ST_CV_POS +: 10]             = cur_cv;
        next_rdata[ST_VALUE_POS +: 8]           = cur_value;
      end
      ADDR_DONE: begin
        next_rdata[13:0]                        = done_loco;
        next_rdata[DONE_TABLE_POS +: 4]         = done_table;
      end
      ADDR_EDIT_ADDR: next_rdata = {24'h000000, edit_tab, edit_idx};
      ADDR_EDIT_DATA: next_rdata = {24'h000000, edit_value};
      default:        next_rdata = 32'h0000_0000;
    endcase
  end

  // read data captured in the setup cycle, valid through the access cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= next_rdata;
    end
  end

  // target locomotive and table choice; index taken as a plain number
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      loco      <= LOCO_RESET;
      table_sel <= TABLE_RESET;
    end else if (wr_en && paddr == ADDR_LOCO) begin
      loco <= pwdata[13:0];
    end else if (wr_en && paddr == ADDR_TABLE) begin
      table_sel <= pwdata[3:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      edit_tab <= 3'h0;
      edit_idx <= 5'h00;
    end else if (wr_en && paddr == ADDR_EDIT_ADDR) begin
      edit_tab <= pwdata[EDIT_TAB_POS +: 3];
      edit_idx <= pwdata[4:0];
    end
  end

  table_store u_store (
    .clk      (clk),
    .rst_n    (rst_n),
    .restore  (restore),
    .rd_tab   (run_tab),
    .rd_idx   (idx),
    .rd_value (entry_value),
    .ed_tab   (edit_tab),
    .ed_idx   (edit_idx),
    .ed_we    (edit_we),
    .ed_wdata (pwdata[7:0]),
    .ed_value (edit_value)
  );

  // word offered to the fifo in each sequencing state
  always_comb begin
    word          = '0;
    word.loco     = run_loco;
    case (state)
      ENTRIES: begin
        word.cv    = CV_FIRST + {5'h00, idx};
        word.value = entry_value;
      end
      CONFIG_BIT: begin
        word.cv       = CV_CONFIG;
        word.bit_mode = 1'b1;
        word.bit_pos  = SEL_BIT;
        word.value    = 8'h01;
      end
      VENDOR_BIT: begin
        word.cv       = CV_VENDOR;
        word.bit_mode = 1'b1;
        word.bit_pos  = SEL_BIT;
        word.value    = 8'h01;
      end
      default: word = '0;
    endcase
  end

  // no acknowledge is awaited; only fifo room paces the sequence
  assign push = (state != IDLE) && fifo_ready;

  // sequencing; cancel has no path here while a download runs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= IDLE;
      idx      <= 5'h00;
      run_loco <= LOCO_RESET;
      run_tab  <= 3'h0;
    end else begin
      case (state)
        IDLE: begin
          if (start_req && index_ok(table_sel)) begin
            state    <= ENTRIES;
            idx      <= 5'h00;
            run_loco <= loco;
            run_tab  <= 3'(table_sel - 4'h1);
          end
        end
        ENTRIES: begin
          if (push) begin
            idx <= idx + 5'h01;
            if (idx == LAST_IDX) begin
              state <= CONFIG_BIT;
            end
          end
        end
        CONFIG_BIT: begin
          if (push) begin
            state <= VENDOR_BIT;
          end
        end
        VENDOR_BIT: begin
          if (push) begin
            state <= IDLE;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end

  // progress shown as the write most recently queued
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_cv    <= 10'h000;
      cur_value <= 8'h00;
    end else if (push) begin
      cur_cv    <= word.cv;
      cur_value <= word.value;
    end
  end

  // completion and refusal flags; clearing only acts while idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done       <= 1'b0;
      done_loco  <= 14'h0000;
      done_table <= 4'h0;
    end else if (state == VENDOR_BIT && push) begin
      done       <= 1'b1;
      done_loco  <= run_loco;
      done_table <= {1'b0, run_tab} + 4'h1;
    end else if (state == IDLE && (cancel_req || start_req)) begin
      done <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rejected <= 1'b0;
    end else if (state == IDLE && start_req) begin
      rejected <= !index_ok(table_sel);
    end else if (state == IDLE && cancel_req) begin
      rejected <= 1'b0;
    end
  end

  sync_fifo #(
    .WIDTH ($bits(cv_write_s)),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (word),
    .out_valid (pkt_valid),
    .out_ready (pkt_ready),
    .out_data  (pkt)
  );

  a_entry_order: assert property (@(posedge clk) disable iff (!rst_n)
    push && state == ENTRIES |-> word.cv == CV_FIRST + {5'h00, idx} && !word.bit_mode
      && word.cv <= CV_LAST)
    else $error("entry write out of order");

  a_config_bit: assert property (@(posedge clk) disable iff (!rst_n)
    push && state == ENTRIES && idx == LAST_IDX |=> state == CONFIG_BIT
      && word.cv == CV_CONFIG && word.bit_mode && word.bit_pos == SEL_BIT && word.value == 8'h01)
    else $error("config bit write does not follow last entry");

  a_vendor_last: assert property (@(posedge clk) disable iff (!rst_n)
    push && state == CONFIG_BIT |=> state == VENDOR_BIT && word.cv == CV_VENDOR
      && word.bit_mode && word.bit_pos == SEL_BIT && word.value == 8'h01)
    else $error("vendor bit write does not follow config bit");

  a_vendor_end: assert property (@(posedge clk) disable iff (!rst_n)
    push && state == VENDOR_BIT |=> state == IDLE && !push)
    else $error("sequence went on after vendor bit write");

  a_cancel_ignored: assert property (@(posedge clk) disable iff (!rst_n)
    state != IDLE && cancel_req && !(state == VENDOR_BIT && push) |=> state != IDLE)
    else $error("cancel stopped a download");

  a_bad_index: assert property (@(posedge clk) disable iff (!rst_n)
    state == IDLE && start_req && !index_ok(table_sel) |=> state == IDLE && rejected && !push)
    else $error("bad table index was accepted");

  a_done_report: assert property (@(posedge clk) disable iff (!rst_n)
    state == VENDOR_BIT && push |=> done && done_loco == $past(run_loco)
      && done_table == {1'b0, $past(run_tab)} + 4'h1)
    else $error("completion report wrong");

  a_status_track: assert property (@(posedge clk) disable iff (!rst_n)
    push |=> cur_cv == $past(word.cv) && cur_value == $past(word.value))
    else $error("status does not follow queued write");

  a_one_loco: assert property (@(posedge clk) disable iff (!rst_n)
    push |-> word.loco == run_loco ##1 (state == IDLE || $stable(run_loco)))
    else $error("download changed target locomotive");

  a_start_run: assert property (@(posedge clk) disable iff (!rst_n)
    state == IDLE && start_req && index_ok(table_sel)
      |=> state == ENTRIES && idx == 5'h00 && run_tab == 3'($past(table_sel) - 4'h1))
    else $error("valid start did not begin at first entry");

  // a start while busy must not retarget the running download
  a_start_busy: assert property (@(posedge clk) disable iff (!rst_n)
    state != IDLE && start_req |=> $stable(run_loco) && $stable(run_tab) && $stable(rejected))
    else $error("start while busy disturbed the download");

  a_loco_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en && paddr == ADDR_LOCO |=> loco == $past(pwdata[13:0]))
    else $error("locomotive address not taken");

  a_table_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en && paddr == ADDR_TABLE |=> table_sel == $past(pwdata[3:0]))
    else $error("table index not taken as plain number");

  a_status_read: assert property (@(posedge clk) disable iff (!rst_n)
    rd_setup && paddr == ADDR_STATUS |=> prdata[ST_CV_POS +: 10] == $past(cur_cv)
      && prdata[ST_VALUE_POS +: 8] == $past(cur_value))
    else $error("status read lost progress");

  a_done_hold: assert property (@(posedge clk) disable iff (!rst_n)
    done && !(state == IDLE && (cancel_req || start_req)) |=> done)
    else $error("completion flag lost without a clear");
endmodule // speed_table_sequencer

// ==== design/sync_fifo.sv ====
// synchronous valid/ready fifo holding outgoing configuration writes
module sync_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;

  assign in_ready  = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
    end else if (in_valid && in_ready) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ptr <= '0;
    end else if (out_valid && out_ready) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end

  a_head_stable: assert property (@(posedge clk) disable iff (!rst_n)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("head word changed before it was taken");
endmodule // sync_fifo

// ==== design/table_store.sv ====
// retained store of the speed tables with a default restore path
module table_store
  import speed_table_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       restore,
  input  wire logic [2:0] rd_tab,
  input  wire logic [4:0] rd_idx,
  output logic [7:0]      rd_value,
  input  wire logic [2:0] ed_tab,
  input  wire logic [4:0] ed_idx,
  input  wire logic       ed_we,
  input  wire logic [7:0] ed_wdata,
  output logic [7:0]      ed_value
);
  // not cleared by rst_n: contents outlive a reset while backup holds
  logic [7:0] mem [N_TABLES][N_ENTRIES];

  assign rd_value = (rd_idx <= LAST_IDX) ? mem[rd_tab][rd_idx] : 8'h00;
  assign ed_value = (ed_idx <= LAST_IDX) ? mem[ed_tab][ed_idx] : 8'h00;

  always_ff @(posedge clk) begin
    if (restore) begin
      for (int t = 0; t < N_TABLES; t++) begin
        for (int e = 0; e < N_ENTRIES; e++) begin
          mem[t][e] <= default_entry(3'(t), 5'(e));
        end
      end
    end else if (ed_we && ed_idx <= LAST_IDX) begin
      mem[ed_tab][ed_idx] <= ed_wdata;
    end
  end

  a_restore_default: assert property (@(posedge clk) disable iff (!rst_n)
    restore |=> ed_value == ((ed_idx <= LAST_IDX) ? default_entry(ed_tab, ed_idx) : 8'h00))
    else $error("table not back at default after restore");
endmodule // table_store

// ==== testbench/speed_table_sequencer_bench.sv ====
// self-checking bench for the speed table download sequencer
module speed_table_sequencer_bench;
  import speed_table_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, psel, penable, pwrite, backup_ok, stall;
  logic        pready, pslverr, pkt_valid, pkt_ready, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  cv_write_s   pkt, exp;
  int          fail_count, check_count, cycles;

  speed_table_sequencer #(.DEPTH(16)) DUT (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .backup_ok(backup_ok), .pkt_valid(pkt_valid),
    .pkt_ready(pkt_ready), .pkt(pkt));
  track_decoder_model SINK (.clk(clk), .rst_n(rst_n), .stall(stall),
    .pkt_valid(pkt_valid), .pkt_ready(pkt_ready), .pkt(pkt));

  function automatic logic [7:0] dflt(input int t, input int e);
    return 8'(((255 - 16 * t) * (e + 1)) / 28);
  endfunction

  task automatic wrap_up();
    if (fail_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [35:0] seen, input logic [35:0] want);
    check_count++;
    if (seen !== want) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic t_reset_and_defaults();
    apb(0, ADDR_LOCO, 0);
    chk(rd, 36'h3);
    apb(0, ADDR_TABLE, 0);
    chk(rd, 36'h1);
    for (int t = 0; t < 8; t += 7) begin
      for (int e = 0; e < 28; e += 27) begin
        apb(1, ADDR_EDIT_ADDR, 32'(t * 32 + e));
        apb(0, ADDR_EDIT_DATA, 0);
        chk(rd, dflt(t, e));
      end
    end
  endtask

  task automatic t_edit();
    apb(1, ADDR_EDIT_ADDR, 32'h45);
    apb(1, ADDR_EDIT_DATA, 32'hA5);
    apb(0, ADDR_EDIT_DATA, 0);
    chk(rd, 36'hA5);
    apb(1, ADDR_EDIT_ADDR, 32'h5C);
    apb(1, ADDR_EDIT_DATA, 32'h77);
    apb(0, ADDR_EDIT_DATA, 0);
    chk(rd, 36'h0);
  endtask

  task automatic t_download();
    int n;
    stall <= 1'b1;
    apb(1, ADDR_LOCO, 32'h11F8);
    apb(1, ADDR_TABLE, 32'h3);
    apb(1, ADDR_CTRL, 32'h1);
    repeat (30) @(posedge clk);
    apb(1, ADDR_CTRL, 32'h3);
    apb(1, ADDR_LOCO, 32'h22);
    apb(0, ADDR_STATUS, 0);
    chk({rd[31:24], rd[17:8], rd[0]}, {dflt(2, 15), 10'd82, 1'b1});
    chk(pkt_valid, 1'b1);
    chk(SINK.got.size(), 0);
    stall <= 1'b0;
    n = 0;
    while (SINK.got.size() < 30 && n < 500) begin
      @(posedge clk);
      n++;
    end
    chk(SINK.got.size(), 30);
    for (int i = 0; i < 28; i++) begin
      exp = '{14'h11F8, 10'(67 + i), 1'b0, 3'h0, (i == 5) ? 8'hA5 : dflt(2, i)};
      chk(SINK.got[i], exp);
    end
    chk(SINK.got[28] & 36'hFFFFFFF01, {14'h11F8, 10'd29, 1'b1, 3'h4, 8'h01});
    chk(SINK.got[29] & 36'hFFFFFFF01, {14'h11F8, 10'd25, 1'b1, 3'h4, 8'h01});
    chk({SINK.mem[29][4], SINK.mem[25][4], SINK.mem[72]}, {2'b11, 8'hA5});
    apb(0, ADDR_DONE, 0);
    chk(rd, 36'h311F8);
    apb(0, ADDR_STATUS, 0);
    chk({rd[17:8], rd[2:0]}, {10'd25, 3'b010});
  endtask

  task automatic t_reject();
    for (int k = 0; k < 2; k++) begin
      apb(1, ADDR_TABLE, k ? 32'h9 : 32'h0);
      apb(1, ADDR_CTRL, 32'h1);
      repeat (8) @(posedge clk);
      apb(0, ADDR_STATUS, 0);
      chk(rd[2:0], 3'b100);
      chk(SINK.got.size(), 30);
      apb(1, ADDR_CTRL, 32'h2);
      apb(0, ADDR_STATUS, 0);
      chk(rd[2:0], 3'b000);
    end
    apb(0, 8'h1C, 0);
    chk({err, rd}, 36'h100000000);
  endtask

  task automatic t_backup_loss();
    backup_ok <= 1'b0;
    repeat (5) @(posedge clk);
    backup_ok <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1, ADDR_EDIT_ADDR, 32'h45);
    apb(0, ADDR_EDIT_DATA, 0);
    chk(rd, dflt(2, 5));
  endtask

  // mid-run reset: registers back to reset values, table edits kept
  task automatic t_mid_reset();
    apb(1, ADDR_EDIT_DATA, 32'h5A);
    apb(1, ADDR_LOCO, 32'h55);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    apb(0, ADDR_LOCO, 0);
    chk(rd, 36'h3);
    apb(0, ADDR_STATUS, 0);
    chk({pkt_valid, rd}, 36'h0);
    apb(1, ADDR_EDIT_ADDR, 32'h45);
    apb(0, ADDR_EDIT_DATA, 0);
    chk(rd, 36'h5A);
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // run ceiling, well above the expected few hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      wrap_up();
    end
  end

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    backup_ok = 1'b0;
    stall = 1'b0;
    fail_count = 0;
    check_count = 0;
    cycles = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    backup_ok <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset_and_defaults();
    t_edit();
    t_download();
    t_reject();
    t_backup_loss();
    t_mid_reset();
    wrap_up();
  end
endmodule // speed_table_sequencer_bench

// ==== testbench/track_decoder_model.sv ====
// behavioural locomotive decoder taking configuration writes straight off the sequencer's outgoing write fifo
module track_decoder_model
  import speed_table_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  stall,
  input  wire logic                  pkt_valid,
  output logic                       pkt_ready,
  input  wire speed_table_pkg::cv_write_s pkt
);
  timeunit 1ns;
  timeprecision 1ps;
  cv_write_s  got [$];
  logic [7:0] mem [0:1023];

  // stall holds the stream back so the fifo in front fills
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pkt_ready <= 1'b0;
    end else begin
      pkt_ready <= !stall;
      if (pkt_valid && pkt_ready) begin
        got.push_back(pkt);
        if (pkt.bit_mode) begin
          mem[pkt.cv][pkt.bit_pos] <= pkt.value[0];
        end else begin
          mem[pkt.cv] <= pkt.value;
        end
      end
    end
  end
endmodule // track_decoder_model
